// *** design/ufmc_defs.svh ***
// Constants of the serial port core: register map, fields, resets, timing
`ifndef UFMC_DEFS_SVH
`define UFMC_DEFS_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define UFMC_IDX_CTRL 8'hd2
`define UFMC_IDX_DATA 8'hd3
`define UFMC_IDX_FMT 8'he5
`define UFMC_IDX_BAUD 8'he6

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define UFMC_CTRL_RST 8'h20
`define UFMC_FMT_RST 8'h0c
`define UFMC_BAUD_RST 16'h000c

// ---------------------------------------------------------------
// Control/status field positions
// ---------------------------------------------------------------
`define UFMC_C_OVR 7
`define UFMC_C_PERR 6
`define UFMC_C_THRE 5
`define UFMC_C_REN 4
`define UFMC_C_TBX 3
`define UFMC_C_RBX 2
`define UFMC_C_TI 1
`define UFMC_C_RI 0

// ---------------------------------------------------------------
// Format field positions
// ---------------------------------------------------------------
`define UFMC_F_MCE 7
`define UFMC_F_PT_HI 6
`define UFMC_F_PT_LO 5
`define UFMC_F_PE 4
`define UFMC_F_DL_HI 3
`define UFMC_F_DL_LO 2
`define UFMC_F_XBE 1
`define UFMC_F_SBL 0

// Baud register: interrupt enable bit
`define UFMC_B_IRQEN 16

// ---------------------------------------------------------------
// Timing: oversampling ticks per bit and stop lengths in ticks
// ---------------------------------------------------------------
`define UFMC_TICK_LAST 5'h0f
`define UFMC_TICK_HALF 5'h07
`define UFMC_STOP1_LAST 5'h0f
`define UFMC_STOP15_LAST 5'h17
`define UFMC_STOP2_LAST 5'h1f

// Receive FIFO
`define UFMC_FIFO_DEPTH 2'h3

`endif

// *** design/ufmc_pkg.sv ***
// Types shared by the serial port core
package ufmc_pkg;

  typedef enum logic [2:0] {
    UFMC_IDLE  = 3'h0,
    UFMC_START = 3'h1,
    UFMC_DATA  = 3'h3,
    UFMC_EXTRA = 3'h2,
    UFMC_STOP  = 3'h6
  } ufmc_frame_e;

  typedef enum logic [1:0] {
    UFMC_PAR_ODD   = 2'h0,
    UFMC_PAR_EVEN  = 2'h1,
    UFMC_PAR_MARK  = 2'h2,
    UFMC_PAR_SPACE = 2'h3
  } ufmc_parity_e;

endpackage

// *** design/ufmc_rx_fifo.sv ***
// Three-entry receive FIFO with registered head-of-queue output
`timescale 1ns/10ps
`include "ufmc_defs.svh"
module ufmc_rx_fifo (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic pop,
  input wire logic [8:0] wdata,
  output logic [8:0] head_r,
  output logic [1:0] count_r
);
  import ufmc_pkg::*;

  logic [8:0] mem_r [0:2];
  logic [1:0] wr_ptr_r;
  logic [1:0] rd_ptr_r;
  logic do_push;
  logic do_pop;
  logic [1:0] wr_nxt;
  logic [1:0] rd_nxt;
  logic [1:0] count_nxt;

  function automatic logic [1:0] inc_ptr(input logic [1:0] p);
    inc_ptr = (p == 2'h2) ? 2'h0 : p + 2'h1;
  endfunction

  always_comb begin
    do_push = push && (count_r != `UFMC_FIFO_DEPTH);
    do_pop = pop && (count_r != 2'h0);
    wr_nxt = do_push ? inc_ptr(wr_ptr_r) : wr_ptr_r;
    rd_nxt = do_pop ? inc_ptr(rd_ptr_r) : rd_ptr_r;
    count_nxt = count_r + {1'b0, do_push} - {1'b0, do_pop};
  end

  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem_r[wr_ptr_r] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= 2'h0;
      rd_ptr_r <= 2'h0;
      count_r <= 2'h0;
      head_r <= 9'h000;
    end else begin
      wr_ptr_r <= wr_nxt;
      rd_ptr_r <= rd_nxt;
      count_r <= count_nxt;
      // Next oldest byte shows at once, bypassing a same-cycle write
      if (count_nxt == 2'h0) begin
        head_r <= 9'h000;
      end else if (do_push && (wr_ptr_r == rd_nxt)) begin
        head_r <= wdata;
      end else begin
        head_r <= mem_r[rd_nxt];
      end
    end
  end

endmodule

// *** design/ufmc_core.sv ***
// Full-duplex serial port core with APB registers and receive FIFO
// Operation
// - Data buffer write loads holding register and clears holding-empty flag.
// - When idle, held byte moves to shifter, starts, holding-empty set.
// - During a frame a new byte waits in holding register.
// - Transmit-done flag sets at stop-bit start; only software clears it.
// - Enabled interrupt requests when transmit-done or receive-ready is set.
// - Extra bit on, parity off: send transmit-extra control bit after data.
// - Parity on: append computed parity of selected type; no extra bit.
// - Receiver starts frames only while receive-enable is 1.
// - Byte stored after stop bit only if FIFO not full, stop bits 1.
// - Frame into full FIFO is lost and sets overrun; software clears it.
// - Frame with a zero stop bit is not stored.
// - Store sets receive-ready; multiprocessor mode needs extra bit 1.
// - Data buffer read returns oldest byte and frees that entry.
// - Receive-ready clears only when FIFO empty; stays set otherwise.
// - Received-extra shows oldest extra bit, or first stop bit.
// - Parity on: mismatch sets parity-error; software clears it.
// - Receive-enable off stops reception; FIFO stays readable.
// - Frame: low start, data LSB first, parity or extra, high stops.
// - Long stop is two bit times, or 1.5 for 5 data bits.
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`include "ufmc_defs.svh"
module ufmc_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic uart_irq
);
  import ufmc_pkg::*;

  localparam logic [11:0] A_CTRL = {2'b00, `UFMC_IDX_CTRL, 2'b00};
  localparam logic [11:0] A_DATA = {2'b00, `UFMC_IDX_DATA, 2'b00};
  localparam logic [11:0] A_FMT = {2'b00, `UFMC_IDX_FMT, 2'b00};
  localparam logic [11:0] A_BAUD = {2'b00, `UFMC_IDX_BAUD, 2'b00};

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  logic acc_done;
  logic sel_ctrl, sel_data, sel_fmt, sel_baud;
  logic wr_ctrl, wr_data, wr_fmt, wr_baud, rd_data;
  logic [7:0] ctrl_rd;
  logic [31:0] rd_mux;
  logic [7:0] fmt_r;
  logic [15:0] baud_div_r;
  logic irq_en_r;
  logic ren_r, tbx_r, ti_r, ri_r, ovr_r, perr_r;
  logic hold_full_r;
  logic [7:0] hold_r;
  logic [8:0] head;
  logic [1:0] fifo_count;

  assign sel_ctrl = (paddr == A_CTRL);
  assign sel_data = (paddr == A_DATA);
  assign sel_fmt = (paddr == A_FMT);
  assign sel_baud = (paddr == A_BAUD);
  assign acc_done = psel && penable && pready;
  assign wr_ctrl = acc_done && pwrite && sel_ctrl && pstrb[0];
  assign wr_data = acc_done && pwrite && sel_data && pstrb[0];
  assign wr_fmt = acc_done && pwrite && sel_fmt && pstrb[0];
  assign wr_baud = acc_done && pwrite && sel_baud;
  assign rd_data = acc_done && !pwrite && sel_data;

  assign ctrl_rd = {ovr_r, perr_r, !hold_full_r, ren_r, tbx_r,
                    head[8], ti_r, ri_r};

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_mux = {24'h00_0000, ctrl_rd};
    end else if (sel_data) begin
      rd_mux = {24'h00_0000, head[7:0]};
    end else if (sel_fmt) begin
      rd_mux = {24'h00_0000, fmt_r};
    end else if (sel_baud) begin
      rd_mux = {15'h0000, irq_en_r, baud_div_r};
    end
  end

  // One wait state: data and error are registered on the same edge that raises pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !(sel_ctrl || sel_data || sel_fmt || sel_baud);
      prdata <= rd_mux;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_r <= `UFMC_FMT_RST;
      baud_div_r <= `UFMC_BAUD_RST;
      irq_en_r <= 1'b0;
      ren_r <= 1'(`UFMC_CTRL_RST >> `UFMC_C_REN);
      tbx_r <= 1'(`UFMC_CTRL_RST >> `UFMC_C_TBX);
    end else begin
      if (wr_fmt) begin
        fmt_r <= pwdata[7:0];
      end
      if (wr_baud && pstrb[0]) begin
        baud_div_r[7:0] <= pwdata[7:0];
      end
      if (wr_baud && pstrb[1]) begin
        baud_div_r[15:8] <= pwdata[15:8];
      end
      if (wr_baud && pstrb[2]) begin
        irq_en_r <= pwdata[`UFMC_B_IRQEN];
      end
      if (wr_ctrl) begin
        ren_r <= pwdata[`UFMC_C_REN];
        tbx_r <= pwdata[`UFMC_C_TBX];
      end
    end
  end

  // ---------------------------------------------------------------
  // Format decode and oversampling tick (16 per bit)
  // ---------------------------------------------------------------
  logic mce, pe, xbe, sbl, has_extra;
  logic [1:0] dlen;
  logic [2:0] last_bit;
  logic [4:0] stop_last;
  logic [15:0] baud_cnt_r;
  logic tick_r;

  assign mce = fmt_r[`UFMC_F_MCE];
  assign pe = fmt_r[`UFMC_F_PE];
  assign xbe = fmt_r[`UFMC_F_XBE];
  assign sbl = fmt_r[`UFMC_F_SBL];
  assign dlen = fmt_r[`UFMC_F_DL_HI:`UFMC_F_DL_LO];
  assign last_bit = {1'b1, dlen} + 3'h0;
  assign has_extra = pe || xbe;
  assign stop_last = !sbl ? `UFMC_STOP1_LAST :
                     (dlen == 2'h0) ? `UFMC_STOP15_LAST :
                     `UFMC_STOP2_LAST;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (baud_cnt_r == 16'h0000) begin
      baud_cnt_r <= baud_div_r;
      tick_r <= 1'b1;
    end else begin
      baud_cnt_r <= baud_cnt_r - 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // Parity of the active data bits for the selected type
  function automatic logic par_bit(input logic [7:0] d,
                                   input logic [1:0] len,
                                   input logic [1:0] pt);
    logic [7:0] m;
    m = d & (8'hff >> (2'h3 - len));
    case (pt)
      UFMC_PAR_ODD: par_bit = ~^m;
      UFMC_PAR_EVEN: par_bit = ^m;
      UFMC_PAR_MARK: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  ufmc_frame_e tx_st_r;
  logic [4:0] tx_cnt_r;
  logic [2:0] tx_bit_r;
  logic [7:0] tx_sh_r;
  logic tx_x_r;
  logic tx_load, tx_end, ti_set;

  assign tx_load = (tx_st_r == UFMC_IDLE) && hold_full_r;
  assign tx_end = tick_r &&
    (tx_cnt_r == ((tx_st_r == UFMC_STOP) ? stop_last : `UFMC_TICK_LAST));
  assign ti_set = tx_end && ((tx_st_r == UFMC_EXTRA) ||
    ((tx_st_r == UFMC_DATA) && (tx_bit_r == last_bit) && !has_extra));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_full_r <= 1'b0;
      hold_r <= 8'h00;
    end else if (wr_data) begin
      hold_full_r <= 1'b1;
      hold_r <= pwdata[7:0];
    end else if (tx_load) begin
      hold_full_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_r <= UFMC_IDLE;
      tx_cnt_r <= 5'h00;
      tx_bit_r <= 3'h0;
      tx_sh_r <= 8'h00;
      tx_x_r <= 1'b0;
      serial_out_pin <= 1'b1;
    end else begin
      if (tick_r) begin
        tx_cnt_r <= tx_end ? 5'h00 : tx_cnt_r + 5'h01;
      end
      unique case (tx_st_r)
        UFMC_IDLE: begin
          if (tx_load) begin
            tx_st_r <= UFMC_START;
            tx_sh_r <= hold_r;
            tx_x_r <= pe ? par_bit(hold_r, dlen, fmt_r[6:5]) : tbx_r;
            tx_cnt_r <= 5'h00;
            serial_out_pin <= 1'b0;
          end
        end
        UFMC_START: begin
          if (tx_end) begin
            tx_st_r <= UFMC_DATA;
            tx_bit_r <= 3'h0;
            serial_out_pin <= tx_sh_r[0];
          end
        end
        UFMC_DATA: begin
          if (tx_end && (tx_bit_r == last_bit)) begin
            tx_st_r <= has_extra ? UFMC_EXTRA : UFMC_STOP;
            serial_out_pin <= has_extra ? tx_x_r : 1'b1;
          end else if (tx_end) begin
            tx_bit_r <= tx_bit_r + 3'h1;
            serial_out_pin <= tx_sh_r[tx_bit_r + 3'h1];
          end
        end
        UFMC_EXTRA: begin
          if (tx_end) begin
            tx_st_r <= UFMC_STOP;
            serial_out_pin <= 1'b1;
          end
        end
        UFMC_STOP: begin
          if (tx_end) begin
            tx_st_r <= UFMC_IDLE;
          end
        end
        default: begin
          tx_st_r <= UFMC_IDLE;
          serial_out_pin <= 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  ufmc_frame_e rx_st_r;
  logic [4:0] rx_cnt_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic rx_x_r, rx_stop1_r;
  logic rx_mid, rx_fin, stop_ok, push, ri_set;
  logic [8:0] push_word;

  assign rx_mid = tick_r && (rx_cnt_r[3:0] == 4'hf);
  assign rx_fin = tick_r && (rx_st_r == UFMC_STOP) &&
    (rx_cnt_r == ((sbl && dlen != 2'h0) ? 5'h1f : 5'h0f));
  assign stop_ok = (rx_cnt_r == 5'h0f) ? serial_in_pin
                                       : (rx_stop1_r && serial_in_pin);
  assign push = rx_fin && stop_ok && (fifo_count != `UFMC_FIFO_DEPTH);
  assign ri_set = push && (!mce || rx_x_r);
  assign push_word = {(xbe && !pe) ? rx_x_r :
                      ((rx_cnt_r == 5'h0f) ? serial_in_pin : rx_stop1_r),
                      rx_sh_r};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_r <= UFMC_IDLE;
      rx_cnt_r <= 5'h00;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_x_r <= 1'b0;
      rx_stop1_r <= 1'b0;
    end else begin
      if (tick_r) begin
        rx_cnt_r <= rx_cnt_r + 5'h01;
      end
      unique case (rx_st_r)
        UFMC_IDLE: begin
          if (ren_r && !serial_in_pin) begin
            rx_st_r <= UFMC_START;
            rx_cnt_r <= 5'h00;
            rx_sh_r <= 8'h00;
          end
        end
        UFMC_START: begin
          if (tick_r && rx_cnt_r == {1'b0, 4'(`UFMC_TICK_HALF)}) begin
            rx_st_r <= serial_in_pin ? UFMC_IDLE : UFMC_DATA;
            rx_cnt_r <= 5'h00;
            rx_bit_r <= 3'h0;
          end
        end
        UFMC_DATA: begin
          if (rx_mid) begin
            rx_sh_r[rx_bit_r] <= serial_in_pin;
            rx_bit_r <= rx_bit_r + 3'h1;
            rx_cnt_r <= 5'h00;
            if (rx_bit_r == last_bit) begin
              rx_st_r <= has_extra ? UFMC_EXTRA : UFMC_STOP;
            end
          end
        end
        UFMC_EXTRA: begin
          if (rx_mid) begin
            rx_x_r <= serial_in_pin;
            rx_cnt_r <= 5'h00;
            rx_st_r <= UFMC_STOP;
          end
        end
        UFMC_STOP: begin
          if (tick_r && rx_cnt_r == 5'h0f) begin
            rx_stop1_r <= serial_in_pin;
          end
          if (rx_fin) begin
            rx_st_r <= UFMC_IDLE;
          end
        end
        default: begin
          rx_st_r <= UFMC_IDLE;
        end
      endcase
    end
  end

  ufmc_rx_fifo u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .push(push),
    .pop(rd_data),
    .wdata(push_word),
    .head_r(head),
    .count_r(fifo_count)
  );

  // ---------------------------------------------------------------
  // Status flags: a hardware set wins over a software clear
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ti_r <= 1'b0;
      ri_r <= 1'b0;
      ovr_r <= 1'b0;
      perr_r <= 1'b0;
      uart_irq <= 1'b0;
    end else begin
      if (ti_set) begin
        ti_r <= 1'b1;
      end else if (wr_ctrl && !pwdata[`UFMC_C_TI]) begin
        ti_r <= 1'b0;
      end
      if (ri_set) begin
        ri_r <= 1'b1;
      end else if (wr_ctrl && !pwdata[`UFMC_C_RI] &&
                   fifo_count == 2'h0) begin
        ri_r <= 1'b0;
      end
      if (rx_fin && fifo_count == `UFMC_FIFO_DEPTH) begin
        ovr_r <= 1'b1;
      end else if (wr_ctrl && !pwdata[`UFMC_C_OVR]) begin
        ovr_r <= 1'b0;
      end
      if (rx_fin && stop_ok && pe &&
          rx_x_r != par_bit(rx_sh_r, dlen, fmt_r[6:5])) begin
        perr_r <= 1'b1;
      end else if (wr_ctrl && !pwdata[`UFMC_C_PERR]) begin
        perr_r <= 1'b0;
      end
      uart_irq <= irq_en_r && (ti_r || ri_r);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence tx_launch_s;
    tx_st_r == UFMC_IDLE && hold_full_r && !wr_data;
  endsequence

  hold_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_data |=> !ctrl_rd[`UFMC_C_THRE])
    else $error("holding flag not cleared by data write");
  launch_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_launch_s |=> ctrl_rd[`UFMC_C_THRE] && tx_st_r == UFMC_START
      && !serial_out_pin)
    else $error("held byte not launched");
  hold_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    hold_full_r && tx_st_r != UFMC_IDLE |=> hold_full_r)
    else $error("held byte lost during frame");
  tx_done_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_st_r != UFMC_STOP ##1 tx_st_r == UFMC_STOP |-> ti_r)
    else $error("transmit-done not set at stop start");
  irq_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_en_r && (ti_r || ri_r) |=> uart_irq)
    else $error("interrupt not requested");
  extra_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_st_r == UFMC_EXTRA |-> serial_out_pin == tx_x_r)
    else $error("extra bit not on line");
  rx_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_st_r == UFMC_IDLE && !ren_r |=> rx_st_r == UFMC_IDLE)
    else $error("frame accepted while disabled");
  overrun_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_fin && fifo_count == `UFMC_FIFO_DEPTH && !rd_data
      |=> ovr_r && $stable(fifo_count))
    else $error("overrun not flagged");
  ready_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    ri_r && fifo_count != 2'h0 |=> ri_r)
    else $error("receive-ready cleared with data left");
  line_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_st_r == UFMC_IDLE |-> serial_out_pin)
    else $error("line low while idle");

endmodule

// *** tb/ufmc_peer.sv ***
// Serial node facing the core across its transmit and receive lines
`timescale 1ns/10ps
module ufmc_peer (
  input wire logic pclk,
  input wire logic tx,
  output logic rx
);
  // ---------------------------------------------------------------
  // Frame driver and sampler
  // ---------------------------------------------------------------
  // Bit time in clock cycles for a divider of zero
  localparam int BIT = 16;
  initial rx = 1'b1;
  // Sends bit 0 first, then idles high for one bit time
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rx <= f[i];
      repeat (BIT) @(posedge pclk);
    end
    rx <= 1'b1;
    repeat (BIT) @(posedge pclk);
  endtask
  // Samples mid-bit; returns at the middle of the last bit
  task automatic grab(input int n, output logic [10:0] v);
    v = '0;
    @(negedge tx);
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      v[i] = tx;
      if (i < n - 1) begin
        repeat (BIT) @(posedge pclk);
      end
    end
  endtask
endmodule

// *** tb/uart_fifo_multiproc_core_tb.sv ***
// Self-checking bench for the serial port core
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
  miscompares++; $display("Error %s expected %h seen %h", n, e, s); \
  end end
module uart_fifo_multiproc_core_tb;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  localparam logic [11:0] A_CTL = 12'h348;
  localparam logic [11:0] A_DAT = 12'h34c;
  localparam logic [11:0] A_FMT = 12'h394;
  localparam logic [11:0] A_BAUD = 12'h398;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rv;
  logic pready, pslverr, rxl, txl, irq, err;
  logic [10:0] g1, g2;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  always #20 pclk = ~pclk;
  ufmc_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(rxl), .serial_out_pin(txl), .uart_irq(irq));
  ufmc_peer u_peer (.pclk(pclk), .tx(txl), .rx(rxl));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [10:0] fr(input logic [7:0] d, input logic x,
                                     input logic s);
    return {s, x, d, 1'b0};
  endfunction
  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    apb(0, A_CTL, 0);
    `CHK("ctrl", 32'h20, rv)
    apb(1, 12'h000, 32'hff);
    `CHK("unmapped", 1'b1, err)
  endtask
  task automatic t_tx();
    apb(1, A_BAUD, 32'h1_0000);
    fork
      u_peer.grab(10, g1);
      begin
        apb(1, A_DAT, 32'h55);
        apb(0, A_CTL, 0);
        `CHK("empty", 1'b1, rv[5])
      end
    join
    `CHK("frame", 11'h2aa, g1)
    apb(0, A_CTL, 0);
    `CHK("txdone", 1'b1, rv[1])
    `CHK("irq", 1'b1, irq)
    apb(1, A_CTL, 0);
    apb(0, A_CTL, 0);
    `CHK("txclr", 1'b0, rv[1])
    `CHK("irqclr", 1'b0, irq)
    fork
      begin
        u_peer.grab(10, g1);
        u_peer.grab(10, g2);
      end
      begin
        apb(1, A_DAT, 32'ha3);
        apb(1, A_DAT, 32'h3c);
        apb(0, A_CTL, 0);
        `CHK("full", 1'b0, rv[5])
      end
    join
    `CHK("first", 11'h346, g1)
    `CHK("second", 11'h278, g2)
  endtask
  task automatic t_xtra();
    logic [3:0] par = 4'b0110;
    repeat (16) @(posedge pclk);
    apb(1, A_FMT, 32'h0e);
    apb(1, A_CTL, 32'h08);
    fork
      u_peer.grab(11, g1);
      apb(1, A_DAT, 32'h81);
    join
    `CHK("extra", 1'b1, g1[9])
    for (int p = 0; p < 4; p++) begin
      repeat (16) @(posedge pclk);
      apb(1, A_FMT, 32'h1c | (32'(p) << 5));
      fork
        u_peer.grab(11, g1);
        apb(1, A_DAT, 32'h07);
      join
      `CHK("parity", par[p], g1[9])
    end
    repeat (16) @(posedge pclk);
  endtask
  task automatic t_rx();
    apb(1, A_FMT, 32'h0c);
    apb(1, A_CTL, 32'h10);
    for (int i = 1; i < 5; i++) begin
      u_peer.send(fr(8'(i * 17), 1'b1, 1'b1), 10);
    end
    apb(0, A_CTL, 0);
    `CHK("ready", 1'b1, rv[0])
    `CHK("overrun", 1'b1, rv[7])
    `CHK("rxextra", 1'b1, rv[2])
    for (int i = 1; i < 4; i++) begin
      apb(1, A_CTL, 32'h10);
      apb(0, A_CTL, 0);
      `CHK("hold", 1'b1, rv[0])
      apb(0, A_DAT, 0);
      `CHK("data", 32'(i * 17), rv)
    end
    apb(1, A_CTL, 32'h10);
    apb(0, A_CTL, 0);
    `CHK("clear", 1'b0, rv[0])
    `CHK("ovrclr", 1'b0, rv[7])
  endtask
  task automatic t_bad();
    u_peer.send(fr(8'h5a, 1'b0, 1'b1), 10);
    apb(0, A_CTL, 0);
    `CHK("badstop", 1'b0, rv[0])
    u_peer.send(fr(8'h66, 1'b1, 1'b1), 10);
    apb(1, A_CTL, 32'h00);
    u_peer.send(fr(8'h77, 1'b1, 1'b1), 10);
    apb(0, A_DAT, 0);
    `CHK("held", 32'h66, rv)
    apb(1, A_CTL, 32'h00);
    apb(0, A_CTL, 0);
    `CHK("off", 1'b0, rv[0])
  endtask
  task automatic t_mp();
    apb(1, A_FMT, 32'h8e);
    apb(1, A_CTL, 32'h10);
    u_peer.send(fr(8'h42, 1'b0, 1'b1), 11);
    apb(0, A_CTL, 0);
    `CHK("dataword", 1'b0, rv[0])
    apb(0, A_DAT, 0);
    u_peer.send(fr(8'h09, 1'b1, 1'b1), 11);
    apb(0, A_CTL, 0);
    `CHK("address", 2'b11, {rv[2], rv[0]})
    `CHK("rxirq", 1'b1, irq)
    apb(0, A_DAT, 0);
    `CHK("addrbyte", 32'h09, rv)
    apb(1, A_CTL, 32'h10);
    apb(1, A_FMT, 32'h0e);
    u_peer.send(fr(8'h5c, 1'b0, 1'b1), 11);
    apb(0, A_CTL, 0);
    `CHK("datawake", 1'b1, rv[0])
    apb(0, A_DAT, 0);
    `CHK("databyte", 32'h5c, rv)
    apb(1, A_FMT, 32'h8e);
  endtask
  task automatic t_long();
    int t0;
    apb(1, A_FMT, 32'h0d);
    u_peer.send(fr(8'h3a, 1'b1, 1'b0), 11);
    apb(0, A_CTL, 0);
    `CHK("stop2low", 1'b0, rv[0])
    u_peer.send(fr(8'h3a, 1'b1, 1'b1), 11);
    apb(0, A_DAT, 0);
    `CHK("longstop", 32'h3a, rv)
    apb(1, A_DAT, 32'h00);
    apb(1, A_DAT, 32'h00);
    @(posedge txl);
    t0 = cycles;
    @(negedge txl);
    // Two bit times of stop plus the one-cycle launch of the held byte
    `CHK("stoplen", 33, cycles - t0)
  endtask
  task automatic t_perr();
    apb(1, A_FMT, 32'h3c);
    u_peer.send(fr(8'h07, 1'b0, 1'b1), 11);
    apb(0, A_CTL, 0);
    `CHK("perr", 1'b1, rv[6])
    apb(0, A_DAT, 0);
    apb(1, A_CTL, 32'h10);
    apb(0, A_CTL, 0);
    `CHK("perrclr", 1'b0, rv[6])
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_tx();
    t_xtra();
    t_rx();
    t_bad();
    t_mp();
    t_perr();
    t_long();
    end_of_test();
  end
endmodule
